// File: rtl/spi_port_pkg.sv
// Constants, states and the state record of the serial master/slave port
`default_nettype none
package spi_port_pkg;
	localparam int           WORD_BITS  = 16;
	localparam int           LEN_W      = 5;
	localparam int           N_SLAVES   = 4;
	localparam int           SLV_W      = 2;
	localparam int           SCNT_W     = 3;
	localparam int           WORDS_W    = 6;
	localparam int           FIFO_DEPTH = 32;
	localparam int           PRESC_W    = 3;
	localparam int           BAUD_W     = 8;
	// Low-speed peripheral clock divisors, stored as terminal counts
	localparam logic [2:0]   PRESC_DIV4_LAST = 3'h3;
	localparam logic [2:0]   PRESC_DIV6_LAST = 3'h5;
	localparam logic [4:0]   LEN_MIN    = 5'h01;
	localparam logic [4:0]   LEN_MAX    = 5'h10;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_LOAD  = 5'h02,
		ST_LEAD  = 5'h04,
		ST_TRAIL = 5'h08,
		ST_END   = 5'h10
	} mst_state_t;

	typedef struct packed {
		mst_state_t                st;
		logic [PRESC_W-1:0]        presc_cnt;
		logic [BAUD_W-1:0]         baud_cnt;
		logic [SLV_W-1:0]          slave_idx;
		logic [WORDS_W-1:0]        word_cnt;
		logic [LEN_W-1:0]          bit_cnt;
		logic [WORD_BITS-1:0]      tx_sr;
		logic [WORD_BITS-1:0]      rx_sr;
		logic [WORD_BITS-1:0]      rx_data;
		logic [SLV_W-1:0]          rx_slave;
		logic                      rx_strobe;
		logic                      valid;
		logic                      overrun;
		logic                      sclk_o;
		logic                      sclk_d;
		logic                      cs_d;
		logic                      reload_pend;
		logic [N_SLAVES-1:0]       cs_n;
	} port_state_t;

	localparam port_state_t STATE_RST = '{
		st: ST_IDLE, presc_cnt: '0, baud_cnt: '0, slave_idx: '0, word_cnt: '0,
		bit_cnt: '0, tx_sr: '0, rx_sr: '0, rx_data: '0, rx_slave: '0,
		rx_strobe: 1'b0, valid: 1'b0, overrun: 1'b0, sclk_o: 1'b0, sclk_d: 1'b0,
		cs_d: 1'b1, reload_pend: 1'b0, cs_n: '1
	};
endpackage
`default_nettype wire

// File: rtl/word_fifo_if.sv
// Stream carrier between the port and its transmit word FIFO
`default_nettype none
interface word_fifo_if #(parameter int WIDTH = 16) ();
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;
	modport fifo_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// File: rtl/spi_word_fifo.sv
// Transmit word FIFO with valid/ready on both sides
`default_nettype none
module spi_word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Stream ports
	word_fifo_if.fifo_side   f
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

	typedef struct packed {
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] count;
	} fifo_state_t;

	fifo_state_t       s_r;
	fifo_state_t       s_nxt;
	logic [WIDTH-1:0]  mem [DEPTH];
	logic              push;
	logic              pop;

	assign f.in_ready  = (s_r.count != CNT_FULL);
	assign f.out_valid = (s_r.count != '0);
	assign f.out_data  = mem[s_r.rd_ptr];

	always_comb begin
		s_nxt = s_r;
		push  = f.in_valid && f.in_ready;
		pop   = f.out_ready && f.out_valid;
		if (push) begin
			s_nxt.wr_ptr = (s_r.wr_ptr == PTR_LAST) ? '0 : PTR_W'(s_r.wr_ptr + 1'b1);
		end
		if (pop) begin
			s_nxt.rd_ptr = (s_r.rd_ptr == PTR_LAST) ? '0 : PTR_W'(s_r.rd_ptr + 1'b1);
		end
		if (push && !pop) begin
			s_nxt.count = CNT_W'(s_r.count + 1'b1);
		end else if (pop && !push) begin
			s_nxt.count = CNT_W'(s_r.count - 1'b1);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Storage carries no reset so it can map onto plain RAM
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[s_r.wr_ptr] <= f.in_data;
		end
	end
endmodule
`default_nettype wire

// File: rtl/spi_master_slave_port.sv
// Serial peripheral port, master or slave, with per-slave word packets
//
// Functional notes
// RULE_01: Word length 1 to 16, full duplex
// RULE_02: One master serves one or more slaves
// RULE_03: Only master drives shift clock; slaves follow
// RULE_04: Select active low; slave data only then
// RULE_05: Shift on one edge, capture on other
// RULE_06: Phase bit 1 moves data half period early
// RULE_07: Polarity bit sets shift clock idle level
// RULE_08: Four clock schemes from polarity and phase
// RULE_09: One slave per step, cyclic order
// RULE_10: Reply received on same clock pulses
// RULE_11: Words concatenated in slave order
// RULE_12: Valid set after all slaves served
// RULE_13: Step while still busy sets overrun
// RULE_14: Shift clock from divided low-speed clock
// RULE_15: Each slave has own select line
// RULE_16: Word count set per slave
// RULE_17: Slave valid set after each exchange
// RULE_18: Unread slave word replaced, overrun set
// RULE_19: Master waits until slave is running
// RULE_20: Slave data read faster than sent
// RULE_21: Idle master: selects high, clock idle
`default_nettype none
module spi_master_slave_port
	import spi_port_pkg::*;
(
	// Clock and reset
	input  wire logic                                mclk,
	input  wire logic                                rst_b,
	// Configuration
	input  wire logic                                master_mode,
	input  wire logic                                cpol,
	input  wire logic                                cpha,
	input  wire logic [LEN_W-1:0]                    word_len,
	input  wire logic                                presc_sel,
	input  wire logic [BAUD_W-1:0]                   baud_div,
	input  wire logic [SCNT_W-1:0]                   slave_count,
	input  wire logic [N_SLAVES-1:0][WORDS_W-1:0]    words_per_slave,
	// Execution step and status
	input  wire logic                                step,
	input  wire logic                                rx_read,
	input  wire logic                                err_clear,
	output logic                                     busy,
	output logic                                     valid,
	output logic                                     overrun,
	// Transmit word stream
	input  wire logic [WORD_BITS-1:0]                tx_data,
	input  wire logic                                tx_valid,
	output logic                                     tx_ready,
	// Received words
	output logic [WORD_BITS-1:0]                     rx_data,
	output logic [SLV_W-1:0]                         rx_slave,
	output logic                                     rx_strobe,
	// Serial pins
	input  wire logic                                serial_shift_clock_i,
	output logic                                     serial_shift_clock_o,
	output logic                                     serial_shift_clock_oe,
	input  wire logic                                serial_out_line_i,
	output logic                                     serial_out_line_o,
	output logic                                     serial_out_line_oe,
	input  wire logic                                serial_in_line_i,
	output logic                                     serial_in_line_o,
	output logic                                     serial_in_line_oe,
	input  wire logic                                dedicated_slave_enable_pin,
	output logic [N_SLAVES-1:0]                      slave_select_n
);
	port_state_t           s_r;
	port_state_t           s_nxt;
	logic [LEN_W-1:0]      len;
	logic                  lsp_tick;
	logic                  half_tick;
	logic [PRESC_W-1:0]    presc_last;
	logic                  bit_in;
	logic [WORD_BITS-1:0]  cap_word;
	logic [LEN_W-1:0]      bits_done;
	logic                  s_lead;
	logic                  s_trail;
	logic                  s_done;
	logic                  m_done;

	word_fifo_if #(.WIDTH(WORD_BITS)) txq ();

	spi_word_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_txq (
		.mclk  (mclk),
		.rst_b (rst_b),
		.f     (txq.fifo_side)
	);

	assign txq.in_valid = tx_valid;
	assign txq.in_data  = tx_data;
	assign tx_ready     = txq.in_ready;

	// Left-align so the first bit out is always the top bit of the register
	function automatic logic [WORD_BITS-1:0] align(input logic [WORD_BITS-1:0] w,
	                                              input logic [LEN_W-1:0] l);
		align = w << (LEN_MAX - l); // [RULE_01]
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.rx_strobe = 1'b0;
		txq.out_ready = 1'b0;
		lsp_tick = 1'b0;
		half_tick = 1'b0;
		m_done = 1'b0;
		s_done = 1'b0;
		len = (word_len < LEN_MIN) ? LEN_MIN : ((word_len > LEN_MAX) ? LEN_MAX : word_len);
		presc_last = presc_sel ? PRESC_DIV6_LAST : PRESC_DIV4_LAST;
		bit_in = master_mode ? serial_in_line_i : serial_out_line_i;
		cap_word = {s_r.rx_sr[WORD_BITS-2:0], bit_in};
		bits_done = cpha ? s_r.bit_cnt : LEN_W'(s_r.bit_cnt + 1'b1);
		s_lead = 1'b0;
		s_trail = 1'b0;
		if (err_clear) begin
			s_nxt.overrun = 1'b0;
		end
		if (master_mode) begin
			// The port alone is the clock source here [RULE_02] [RULE_03]
			if (step && s_r.st != ST_IDLE) begin
				s_nxt.overrun = 1'b1; // [RULE_13]
			end
			if (s_r.st == ST_LEAD || s_r.st == ST_TRAIL) begin
				lsp_tick = (s_r.presc_cnt == presc_last); // [RULE_14]
				s_nxt.presc_cnt = lsp_tick ? '0 : PRESC_W'(s_r.presc_cnt + 1'b1);
				if (lsp_tick) begin
					half_tick = (s_r.baud_cnt == baud_div);
					s_nxt.baud_cnt = half_tick ? '0 : BAUD_W'(s_r.baud_cnt + 1'b1);
				end
			end
			case (s_r.st)
				ST_IDLE: begin
					s_nxt.sclk_o = cpol; // [RULE_07] [RULE_21]
					s_nxt.cs_n = '1; // [RULE_21]
					s_nxt.presc_cnt = '0;
					s_nxt.baud_cnt = '0;
					if (step) begin
						s_nxt.word_cnt = '0;
						if (s_r.slave_idx == '0) begin
							s_nxt.valid = 1'b0;
						end
						// [RULE_16]
						s_nxt.st = (words_per_slave[s_r.slave_idx] == '0) ? ST_END : ST_LOAD;
					end
				end
				ST_LOAD: begin
					// Clock stalls while the queue is empty rather than sending junk
					txq.out_ready = 1'b1;
					s_nxt.sclk_o = cpol;
					if (txq.out_valid) begin
						s_nxt.tx_sr = align(txq.out_data, len);
						s_nxt.rx_sr = '0;
						s_nxt.bit_cnt = '0;
						s_nxt.presc_cnt = '0;
						s_nxt.baud_cnt = '0;
						// [RULE_04] [RULE_09] [RULE_15]
						s_nxt.cs_n = ~(N_SLAVES'(1) << s_r.slave_idx);
						s_nxt.st = ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (half_tick) begin
						s_nxt.sclk_o = ~cpol; // [RULE_08]
						if (cpha) begin
							s_nxt.rx_sr = cap_word; // [RULE_05] [RULE_06] [RULE_10]
							s_nxt.bit_cnt = LEN_W'(s_r.bit_cnt + 1'b1);
						end else if (s_r.bit_cnt != '0) begin
							s_nxt.tx_sr = s_r.tx_sr << 1; // [RULE_05]
						end
						s_nxt.st = ST_TRAIL;
					end
				end
				ST_TRAIL: begin
					if (half_tick) begin
						s_nxt.sclk_o = cpol;
						if (cpha) begin
							s_nxt.tx_sr = s_r.tx_sr << 1; // [RULE_05] [RULE_06]
						end else begin
							s_nxt.rx_sr = cap_word; // [RULE_05] [RULE_10]
							s_nxt.bit_cnt = bits_done;
						end
						if (bits_done == len) begin
							m_done = 1'b1;
							// Words leave in slave then word order [RULE_11]
							s_nxt.rx_data = cpha ? s_r.rx_sr : cap_word;
							s_nxt.rx_slave = s_r.slave_idx;
							s_nxt.rx_strobe = 1'b1;
							s_nxt.word_cnt = WORDS_W'(s_r.word_cnt + 1'b1);
							if (WORDS_W'(s_r.word_cnt + 1'b1) == words_per_slave[s_r.slave_idx]) begin
								s_nxt.st = ST_END;
							end else begin
								s_nxt.st = ST_LOAD;
							end
						end else begin
							s_nxt.st = ST_LEAD;
						end
					end
				end
				ST_END: begin
					s_nxt.cs_n = '1;
					s_nxt.sclk_o = cpol;
					s_nxt.st = ST_IDLE;
					if (SCNT_W'({1'b0, s_r.slave_idx} + 1'b1) >= slave_count) begin
						s_nxt.slave_idx = '0; // [RULE_09]
						s_nxt.valid = 1'b1; // [RULE_12]
					end else begin
						s_nxt.slave_idx = SLV_W'(s_r.slave_idx + 1'b1);
					end
				end
				default: begin
					s_nxt.st = ST_IDLE;
				end
			endcase
		end else begin
			// Slave: follow the external clock, sampled each system clock [RULE_03]
			s_nxt.st = ST_IDLE;
			s_nxt.cs_n = '1;
			s_nxt.sclk_o = cpol;
			s_nxt.sclk_d = serial_shift_clock_i;
			s_nxt.cs_d = dedicated_slave_enable_pin;
			s_lead = (s_r.sclk_d == cpol) && (serial_shift_clock_i != cpol);
			s_trail = (s_r.sclk_d != cpol) && (serial_shift_clock_i == cpol);
			// A read and a fresh word in one cycle: the fresh word wins [RULE_20]
			if (rx_read) begin
				s_nxt.valid = 1'b0;
			end
			if (dedicated_slave_enable_pin) begin
				s_nxt.bit_cnt = '0; // [RULE_04]
				s_nxt.reload_pend = 1'b0;
			end else if (s_r.cs_d || (s_trail && s_r.reload_pend)) begin
				txq.out_ready = 1'b1;
				s_nxt.tx_sr = txq.out_valid ? align(txq.out_data, len) : '0;
				s_nxt.rx_sr = '0;
				s_nxt.bit_cnt = '0;
				s_nxt.reload_pend = 1'b0;
			end else if ((s_lead && cpha) || (s_trail && !cpha)) begin
				s_nxt.rx_sr = cap_word; // [RULE_05] [RULE_08]
				s_nxt.bit_cnt = LEN_W'(s_r.bit_cnt + 1'b1);
				if (LEN_W'(s_r.bit_cnt + 1'b1) == len) begin
					s_done = 1'b1;
					s_nxt.rx_data = cap_word;
					s_nxt.rx_slave = '0;
					s_nxt.rx_strobe = 1'b1;
					s_nxt.valid = 1'b1; // [RULE_17]
					if (s_r.valid && !rx_read) begin
						s_nxt.overrun = 1'b1; // [RULE_18]
					end
					if (cpha) begin
						s_nxt.reload_pend = 1'b1; // [RULE_06]
					end else begin
						txq.out_ready = 1'b1;
						s_nxt.tx_sr = txq.out_valid ? align(txq.out_data, len) : '0;
						s_nxt.rx_sr = '0;
						s_nxt.bit_cnt = '0;
					end
				end
			end else if ((s_trail && cpha) || (s_lead && !cpha && s_r.bit_cnt != '0)) begin
				s_nxt.tx_sr = s_r.tx_sr << 1; // [RULE_05] [RULE_06]
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy                  = (s_r.st != ST_IDLE);
	assign valid                 = s_r.valid;
	assign overrun               = s_r.overrun;
	assign rx_data               = s_r.rx_data;
	assign rx_slave              = s_r.rx_slave;
	assign rx_strobe             = s_r.rx_strobe;
	assign slave_select_n        = s_r.cs_n;
	assign serial_shift_clock_o  = s_r.sclk_o;
	assign serial_shift_clock_oe = master_mode; // [RULE_03]
	assign serial_out_line_o     = s_r.tx_sr[WORD_BITS-1];
	assign serial_out_line_oe    = master_mode;
	assign serial_in_line_o      = s_r.tx_sr[WORD_BITS-1];
	// Slave output released whenever its select is high [RULE_04]
	assign serial_in_line_oe     = !master_mode && !dedicated_slave_enable_pin;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	property p_one_select;
		master_mode |-> $onehot0(~slave_select_n);
	endproperty
	a_one_select: assert property (p_one_select) // [RULE_09]
		else $error("more than one slave selected");

	property p_idle_lines;
		master_mode && $past(master_mode) && $past(rst_b) && !busy && $stable(cpol)
			|-> (slave_select_n == '1) && (serial_shift_clock_o == cpol);
	endproperty
	a_idle_lines: assert property (p_idle_lines) // [RULE_21]
		else $error("idle master lines not at rest");

	property p_step_overrun;
		master_mode && step && busy |=> overrun;
	endproperty
	a_step_overrun: assert property (p_step_overrun) // [RULE_13]
		else $error("step while busy did not flag overrun");

	property p_valid_after_end;
		master_mode && $rose(valid) |-> $past(s_r.st) == ST_END && slave_select_n == '1;
	endproperty
	a_valid_after_end: assert property (p_valid_after_end) // [RULE_12]
		else $error("master valid rose outside round end");

	property p_slave_no_clock;
		!master_mode |-> !serial_shift_clock_oe && !serial_out_line_oe && slave_select_n == '1;
	endproperty
	a_slave_no_clock: assert property (p_slave_no_clock) // [RULE_03]
		else $error("slave drives master-owned lines");

	property p_slave_valid;
		!master_mode && s_done |=> valid && rx_strobe;
	endproperty
	a_slave_valid: assert property (p_slave_valid) // [RULE_17]
		else $error("slave exchange did not raise valid");

	property p_slave_overrun;
		!master_mode && s_done && valid && !rx_read |=> overrun;
	endproperty
	a_slave_overrun: assert property (p_slave_overrun) // [RULE_18]
		else $error("unread slave word replaced without overrun");

	property p_lead_edge;
		master_mode && s_r.st == ST_LEAD && half_tick |=> serial_shift_clock_o != cpol;
	endproperty
	a_lead_edge: assert property (p_lead_edge) // [RULE_08]
		else $error("leading shift clock edge missing");

	property p_presc_period;
		master_mode && lsp_tick && !presc_sel && s_r.st == ST_LEAD && s_nxt.st == ST_LEAD
			|=> !lsp_tick [*3] ##1 (lsp_tick || s_r.st != ST_LEAD);
	endproperty
	a_presc_period: assert property (p_presc_period) // [RULE_14]
		else $error("low-speed clock period not four cycles");

	property p_select_during_word;
		master_mode && (s_r.st == ST_LEAD || s_r.st == ST_TRAIL) |-> slave_select_n != '1;
	endproperty
	a_select_during_word: assert property (p_select_during_word) // [RULE_04]
		else $error("shift clock runs without a select");

	c_round_done: cover property (master_mode && $rose(valid));
	c_master_overrun: cover property (master_mode && $rose(overrun));
	c_slave_word: cover property (!master_mode && rx_strobe);
	c_queue_full: cover property (!tx_ready);
endmodule
`default_nettype wire

// File: dv/spi_far_slaves.sv
// Behavioural slave devices on the far side of the master port
`default_nettype none
module spi_far_slaves
	import spi_port_pkg::*;
(
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                rst_b,
	// Scheme and length
	input  wire logic                cpol,
	input  wire logic                cpha,
	input  wire logic [LEN_W-1:0]    word_len,
	// Serial lines
	input  wire logic [N_SLAVES-1:0] sel_n,
	input  wire logic                sck,
	input  wire logic                mosi,
	output logic                     miso
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [WORD_BITS-1:0] got_q[$];
	logic [WORD_BITS-1:0] sr;
	logic [WORD_BITS-1:0] rsr;
	logic [WORD_BITS-1:0] w;
	logic [WORD_BITS-1:0] nw;
	logic [5:0]           cnt;
	logic [4:0]           k;
	logic [1:0]           s;
	logic                 sck_d;
	logic                 idle_d;
	always_comb begin
		s = 2'h0;
		for (int i = 0; i < N_SLAVES; i++) if (!sel_n[i]) s = 2'(i);
	end
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			miso <= 1'b0;
			sck_d <= 1'b0;
			idle_d <= 1'b1;
			cnt <= 6'h00;
			k <= 5'h00;
			sr <= 16'h0000;
			rsr <= 16'h0000;
		end else begin
			sck_d <= sck;
			idle_d <= &sel_n;
			if (&sel_n) begin
				// No pull on this line, so a released line keeps moving
				miso <= ~miso;
			end else if (idle_d) begin
				// A select fall starts the first word of a frame, a master that waits is assumed
				nw = {8'h3c, s, cnt};
				sr <= nw;
				k <= 5'h00;
				if (cpha) miso <= nw[word_len-5'h01];
			end else if (sck != sck_d) begin
				if ((sck != cpol) == cpha) begin
					w = (k == 5'h00) ? {15'h0000, mosi} : {rsr[14:0], mosi};
					rsr <= w;
					k <= k + 5'h01;
					if (k == word_len - 5'h01) begin
						got_q.push_back(w);
						k <= 5'h00;
						cnt <= cnt + 6'h01;
						sr <= {8'h3c, s, cnt + 6'h01};
					end
				end else begin
					miso <= sr[word_len-5'h01-k];
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/spi_master_slave_port_tb_top.sv
// Self-checking bench for the serial master/slave port
`default_nettype none
module spi_master_slave_port_tb_top;
	import spi_port_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, rst_b, master_mode, cpol, cpha, presc_sel, step, rx_read, err_clear;
	logic tx_valid, tx_ready, busy, valid, overrun, rx_strobe, sck_i, sdi, dse, miso_m;
	logic sck_o, sck_oe, so_o, so_oe, si_o, si_oe;
	logic [LEN_W-1:0]                 word_len;
	logic [BAUD_W-1:0]                baud_div;
	logic [SCNT_W-1:0]                slave_count;
	logic [N_SLAVES-1:0][WORDS_W-1:0] words_per_slave;
	logic [WORD_BITS-1:0]             tx_data, rx_data, got;
	logic [SLV_W-1:0]                 rx_slave;
	logic [N_SLAVES-1:0]              sel_n, sel_or;
	logic [WORD_BITS-1:0]             rxq[$];
	logic [SLV_W-1:0]                 rsq[$];
	logic [4:0]                       lens[4] = '{5'h01, 5'h10, 5'h08, 5'h05};
	int failures, check_count, rcnt, cyc, last, gap, ne;
	logic sck_p;
	// Shared pins resolved from the port's output enables alone
	wire logic sck_w = sck_oe ? sck_o : sck_i;
	wire logic mosi_w = so_oe ? so_o : sdi;
	wire logic miso_w = si_oe ? si_o : miso_m;
	spi_master_slave_port u_dut (.mclk, .rst_b, .master_mode, .cpol, .cpha, .word_len,
		.presc_sel, .baud_div, .slave_count, .words_per_slave, .step, .rx_read, .err_clear,
		.busy, .valid, .overrun, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_slave,
		.rx_strobe, .serial_shift_clock_i(sck_w), .serial_shift_clock_o(sck_o),
		.serial_shift_clock_oe(sck_oe), .serial_out_line_i(mosi_w), .serial_out_line_o(so_o),
		.serial_out_line_oe(so_oe), .serial_in_line_i(miso_w), .serial_in_line_o(si_o),
		.serial_in_line_oe(si_oe), .dedicated_slave_enable_pin(dse), .slave_select_n(sel_n));
	spi_far_slaves u_model (.mclk, .rst_b, .cpol, .cpha, .word_len, .sel_n, .sck(sck_w),
		.mosi(mosi_w), .miso(miso_m));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Half period taken from the first two clock edges of a frame only
	always @(posedge mclk) begin
		cyc++;
		if (&sel_n) ne = 0;
		else if (sck_o !== sck_p) begin
			if (ne == 1) gap = cyc - last;
			last = cyc;
			ne++;
		end
		sck_p = sck_o;
		sel_or = sel_or | ~sel_n;
		if (rx_strobe === 1'b1) begin
			rxq.push_back(rx_data);
			rsq.push_back(rx_slave);
		end
	end
	function automatic logic [15:0] msk(input logic [4:0] l);
		return 16'((32'h1 << l) - 32'h1);
	endfunction
	function automatic logic [15:0] rep(input int s, input int c, input logic [4:0] l);
		return {8'h3c, 2'(s), 6'(c)} & msk(l);
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic push(input logic [15:0] w);
		tx_data <= w;
		tx_valid <= 1'b1;
		do @(posedge mclk); while (tx_ready !== 1'b1);
	endtask
	task automatic pulse_step;
		step <= 1'b1;
		@(posedge mclk);
		step <= 1'b0;
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 20000; i++) begin
			@(posedge mclk);
			if (busy === 1'b0) return;
		end
		failures++;
		$display("wait for idle timed out");
	endtask
	// Plays master on the pins, scheme zero, eight bits
	task automatic sx(input logic [7:0] w);
		got = 16'h0000;
		dse <= 1'b0;
		sdi <= w[7];
		repeat (5) @(posedge mclk);
		chk(si_oe, 1'b1);
		for (int i = 7; i >= 0; i--) begin
			sck_i <= 1'b1;
			repeat (5) @(posedge mclk);
			got = {got[14:0], miso_w};
			sck_i <= 1'b0;
			if (i > 0) sdi <= w[i-1];
			repeat (5) @(posedge mclk);
		end
		dse <= 1'b1;
		repeat (6) @(posedge mclk);
	endtask
	initial begin
		#300us;
		failures++;
		$display("watchdog expired");
		stop_test();
	end
	initial begin
		{rst_b, step, rx_read, err_clear, tx_valid, sck_i, sdi, presc_sel} = 8'h00;
		{master_mode, cpol, cpha, dse} = 4'hf;
		{word_len, baud_div, slave_count, tx_data} = {5'h08, 8'h00, 3'h2, 16'h0000};
		words_per_slave = {6'h00, 6'h00, 6'h02, 6'h03};
		{failures, check_count, rcnt, cyc, last, gap, ne} = '0;
		repeat (3) @(posedge mclk);
		chk({busy, valid, overrun, rx_strobe, tx_ready, sel_n}, 16'h001f);
		@(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(sck_o, 1'b1);
		chk(sck_oe, 1'b1);
		chk(so_oe, 1'b1);
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			cpol <= m[1];
			cpha <= ~m[0];
			word_len <= lens[m];
			presc_sel <= m[0];
			baud_div <= 8'(m);
			repeat (2) @(posedge mclk);
			chk(sck_o, m[1]);
			chk(sel_n, 4'hf);
			for (int n = 0; n < 5; n++) push(16'hb6d1 ^ 16'(n * 257 + m * 4099));
			tx_valid <= 1'b0;
			rxq.delete();
			u_model.got_q.delete();
			sel_or = 4'h0;
			pulse_step();
			wait_idle();
			chk(valid, 1'b0);
			chk(sel_or, 4'h1);
			sel_or = 4'h0;
			pulse_step();
			wait_idle();
			chk(valid, 1'b1);
			chk(sel_or, 4'h2);
			chk(16'(gap), 16'((m[0] ? 6 : 4) * (m + 1)));
			chk(16'(rxq.size()), 16'h0005);
			for (int n = 0; n < 5; n++) begin
				chk(u_model.got_q[n], (16'hb6d1 ^ 16'(n * 257 + m * 4099)) & msk(lens[m]));
				chk(rxq[n], rep(n < 3 ? 0 : 1, rcnt + n, lens[m]));
				chk(rsq[n], n < 3 ? 16'h0 : 16'h1);
			end
			rcnt += 5;
			chk(sck_o, m[1]);
		end
		$display("test modes done");
		for (int n = 0; n < 3; n++) push(16'h0011 * 16'(n));
		tx_valid <= 1'b0;
		pulse_step();
		repeat (3) @(posedge mclk);
		chk(overrun, 1'b0);
		pulse_step();
		@(posedge mclk);
		chk(overrun, 1'b1);
		wait_idle();
		err_clear <= 1'b1;
		@(posedge mclk);
		err_clear <= 1'b0;
		@(posedge mclk);
		chk(overrun, 1'b0);
		rcnt += 3;
		$display("test overrun done");
		{word_len, baud_div, presc_sel} <= {5'h04, 8'h00, 1'b0};
		words_per_slave[1] <= 6'h20;
		for (int n = 0; n < 32; n++) push(16'(n));
		tx_data <= 16'h00ff;
		repeat (3) @(posedge mclk);
		chk(tx_ready, 1'b0);
		tx_valid <= 1'b0;
		rxq.delete();
		u_model.got_q.delete();
		pulse_step();
		wait_idle();
		chk(valid, 1'b1);
		chk(tx_ready, 1'b1);
		chk(16'(u_model.got_q.size()), 16'h0020);
		for (int n = 0; n < 32; n++) begin
			chk(u_model.got_q[n], 16'(n) & 16'h000f);
			chk(rxq[n], rep(1, rcnt + n, 5'h04));
		end
		$display("test buffer done");
		{master_mode, cpol, cpha, word_len} <= {1'b0, 1'b0, 1'b1, 5'h08};
		push(16'h00a5);
		push(16'h005c);
		push(16'h0033);
		tx_valid <= 1'b0;
		// Master round left valid high; consume it so the first word is no overrun
		rx_read <= 1'b1;
		@(posedge mclk);
		rx_read <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(valid, 1'b0);
		chk({sck_oe, si_oe}, 16'h0);
		sx(8'h3e);
		chk(got & 16'h00ff, 16'h00a5);
		chk(valid, 1'b1);
		chk(overrun, 1'b0);
		chk(rx_data, 16'h003e);
		rx_read <= 1'b1;
		@(posedge mclk);
		rx_read <= 1'b0;
		@(posedge mclk);
		chk(valid, 1'b0);
		// Each word end pulls the next queued word; one pulled before the select rises is lost
		sx(8'hc1);
		chk(got & 16'h00ff, 16'h0033);
		chk({valid, overrun}, 16'h2);
		sx(8'h7b);
		chk(got & 16'h00ff, 16'h0000);
		chk(overrun, 1'b1);
		chk(rx_data, 16'h007b);
		$display("test slave done");
		stop_test();
	end
endmodule
`default_nettype wire
